// >>> pwo_regs.svh
`ifndef PWO_REGS_SVH
`define PWO_REGS_SVH

// register byte offsets on the AXI4-Lite bus (low eight address bits decoded)
`define PWO_OFS_CTRL        8'h00
`define PWO_OFS_MODE        8'h04
`define PWO_OFS_DUTY        8'h08
`define PWO_OFS_STATUS      8'h0C
`define PWO_OFS_CLEAR       8'h10
`define PWO_OFS_ENABLE      8'h14
`define PWO_OFS_COUNT       8'h18

// timer_control_word fields
`define PWO_CTRL_TFF        7
`define PWO_CTRL_SRC_HI     6
`define PWO_CTRL_SRC_LO     4
`define PWO_CTRL_RUN        3
`define PWO_CTRL_MASK       8'hF8
`define PWO_CTRL_RESET      8'h00

// mode register fields
`define PWO_MODE_DVSEL      0
`define PWO_MODE_SLOW       1
`define PWO_MODE_RESET      2'h0

// interrupt status / clear / enable layout
`define PWO_IRQ_CYCLE_END   0

// counter and duty
`define PWO_CNT_ZERO        8'h00
`define PWO_CNT_MAX         8'hFF
`define PWO_DUTY_RESET      8'h00

// prescaler taps: a tap fires when these low chain bits are all ones
`define PWO_TAP_DIV2        11'h001
`define PWO_TAP_DIV8        11'h007
`define PWO_TAP_DIV32       11'h01F
`define PWO_TAP_DIV128      11'h07F
`define PWO_TAP_DIV2048     11'h7FF
`define PWO_FS_TAP_DIV8     3'h7

// divider defaults: fc and fs enables derived from the 100 MHz aclk
`define PWO_FC_DIV_DEFAULT  6
`define PWO_FS_DIV_DEFAULT  3052

`endif

// >>> pwo_pkg.sv
package pwo_pkg;

  // source clock choices of the counter
  typedef enum logic [2:0] {
    PWO_SRC_DIV2048 = 3'h0,  // fc/2^11, or fs/2^3 with divider_select_bit
    PWO_SRC_DIV128  = 3'h1,
    PWO_SRC_DIV32   = 3'h2,
    PWO_SRC_DIV8    = 3'h3,
    PWO_SRC_FS      = 3'h4,
    PWO_SRC_DIV2    = 3'h5,
    PWO_SRC_FC      = 3'h6,
    PWO_SRC_NONE    = 3'h7
  } pwo_src_type;

  typedef enum logic [1:0] {
    PWO_RESP_OKAY   = 2'h0,
    PWO_RESP_SLVERR = 2'h2
  } pwo_resp_type;

endpackage : pwo_pkg

// >>> pwo_clk_sel.sv
`include "pwo_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module pwo_clk_sel
  import pwo_pkg::*;
#(
  parameter int FC_DIV = `PWO_FC_DIV_DEFAULT,
  parameter int FS_DIV = `PWO_FS_DIV_DEFAULT
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire pwo_src_type src_sel,
  input  wire logic        dv_sel,
  input  wire logic        slow_mode,
  input  wire logic        stop_mode,
  output logic             tick
);

  logic [15:0] fc_div_ff;
  logic [15:0] fs_div_ff;
  logic [10:0] fc_chain_ff;
  logic [2:0]  fs_chain_ff;
  logic        tick_ff;

  // true when all bits of the mask are set in the chain
  function automatic logic low_ones(input logic [10:0] v, input logic [10:0] m);
    low_ones = ((v & m) == m);
  endfunction : low_ones

  wire logic fc_en   = (fc_div_ff == 16'(FC_DIV - 1));
  wire logic fs_en   = (fs_div_ff == 16'(FS_DIV - 1));
  wire logic fc_d2   = fc_en & low_ones(fc_chain_ff, `PWO_TAP_DIV2);
  wire logic fc_d8   = fc_en & low_ones(fc_chain_ff, `PWO_TAP_DIV8);
  wire logic fc_d32  = fc_en & low_ones(fc_chain_ff, `PWO_TAP_DIV32);
  wire logic fc_d128 = fc_en & low_ones(fc_chain_ff, `PWO_TAP_DIV128);
  wire logic fc_d2k  = fc_en & low_ones(fc_chain_ff, `PWO_TAP_DIV2048);
  wire logic fs_d8   = fs_en & (fs_chain_ff == `PWO_FS_TAP_DIV8);

  // normal mode selection; divider_select_bit swaps the slowest tap to fs/8
  wire logic sel_norm = (src_sel == PWO_SRC_DIV2048) ? (dv_sel ? fs_d8 : fc_d2k) :
                        (src_sel == PWO_SRC_DIV128)  ? fc_d128 :
                        (src_sel == PWO_SRC_DIV32)   ? fc_d32  :
                        (src_sel == PWO_SRC_DIV8)    ? fc_d8   :
                        (src_sel == PWO_SRC_FS)      ? fs_en   :
                        (src_sel == PWO_SRC_DIV2)    ? fc_d2   :
                        (src_sel == PWO_SRC_FC)      ? fc_en   : 1'b0;
  // slow and sleep modes have only the fs based sources
  wire logic sel_slow = (src_sel == PWO_SRC_DIV2048) ? fs_d8 :
                        (src_sel == PWO_SRC_FS)      ? fs_en : 1'b0;
  // oscillators stand still in stop mode, so from its second cycle on no tick reaches the counter
  wire logic nxt_tick = stop_mode ? 1'b0 : (slow_mode ? sel_slow : sel_norm); // [R14] [R13]

  // free running dividers; they never stop so phase stays consistent across sources
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fc_div_ff   <= '0;
      fs_div_ff   <= '0;
      fc_chain_ff <= '0;
      fs_chain_ff <= '0;
      tick_ff     <= 1'b0;
    end else begin
      fc_div_ff   <= fc_en ? '0 : fc_div_ff + 16'h0001;
      fs_div_ff   <= fs_en ? '0 : fs_div_ff + 16'h0001;
      fc_chain_ff <= fc_en ? fc_chain_ff + 11'h001 : fc_chain_ff;
      fs_chain_ff <= fs_en ? fs_chain_ff + 3'h1 : fs_chain_ff;
      tick_ff     <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule : pwo_clk_sel

`default_nettype wire

// >>> pwo_pwm8.sv
`include "pwo_regs.svh"
`timescale 1ns/1ps
`default_nettype none

// Function
// [R1] output comes from an eight-bit up-counter clocked by the selected source
// [R2] counter equal to active duty inverts the flop; counter keeps counting
// [R3] overflow inverts the flop again, clears counter, raises cycle-end interrupt
// [R4] flop start level comes from the control bit; reset clears flop
// [R5] the pin always shows the inverse of the flop
// [R6] duty written while running waits in the buffer until cycle end
// [R7] duty written while stopped becomes active right after the write
// [R8] duty reads return the buffer contents, not the active value
// [R9] software sets the port output latch of the pin to one first
// [R10] software updates duty right after cycle-end; coincident write is risky
// [R11] stopping holds the pin; level changes only by a later flop write
// [R12] to park high, clear run bit 3 first, then flop bit 7
// [R13] software stops the timer before stop mode; no ticks during stop
// [R14] source selectable among seven clocks; only fs ones in slow mode
// [R15] one output period is 256 source clock ticks
module pwo_pwm8
  import pwo_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int FC_DIV = `PWO_FC_DIV_DEFAULT,
  parameter int FS_DIV = `PWO_FS_DIV_DEFAULT
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              stop_mode,
  output logic                   modulated_out_pin,
  output logic                   cycle_end_interrupt
);

  // write channel holding registers
  logic              aw_hold_ff;
  logic [7:0]        aw_addr_ff;
  logic              w_hold_ff;
  logic [7:0]        w_data_ff;
  logic              w_lane0_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  // read channel registers
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;
  // block state
  logic [7:0]        ctrl_ff;
  logic [1:0]        mode_ff;
  logic [7:0]        duty_buf_ff;
  logic [7:0]        duty_act_ff;
  logic [7:0]        cnt_ff;
  logic              flop_ff;
  logic              pin_ff;
  logic              sts_ff;
  logic              en_ff;
  logic              irq_ff;
  logic              tick;

  // a byte offset is one of the seven mapped words
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `PWO_OFS_CTRL)   || (a == `PWO_OFS_MODE)  ||
                (a == `PWO_OFS_DUTY)   || (a == `PWO_OFS_STATUS) ||
                (a == `PWO_OFS_CLEAR)  || (a == `PWO_OFS_ENABLE) ||
                (a == `PWO_OFS_COUNT);
  endfunction : is_mapped

  // protection bits carry no meaning here; low address bits select the word
  wire logic [7:0] ar_ofs = s_axi_araddr[7:0];
  wire logic       unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_wstrb[3:1],
                                   s_axi_wdata[31:8], s_axi_awaddr, s_axi_araddr};

  // ---------------------------------------------------------------------------
  // AXI4-Lite write side: address and data taken in either order, answer after both
  assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready  = !w_hold_ff && !bvalid_ff;
  wire logic wr_go     = aw_hold_ff && w_hold_ff && !bvalid_ff;
  wire logic wr_ok     = is_mapped(aw_addr_ff);

  // only byte lane 0 carries register bits; a write without it changes nothing
  wire logic wr_byte   = wr_go && w_lane0_ff;
  wire logic wr_ctrl   = wr_byte && (aw_addr_ff == `PWO_OFS_CTRL);
  wire logic wr_mode   = wr_byte && (aw_addr_ff == `PWO_OFS_MODE);
  wire logic wr_duty   = wr_byte && (aw_addr_ff == `PWO_OFS_DUTY);
  wire logic wr_clear  = wr_byte && (aw_addr_ff == `PWO_OFS_CLEAR);
  wire logic wr_enable = wr_byte && (aw_addr_ff == `PWO_OFS_ENABLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr[7:0];
    end else if (wr_go) begin
      aw_hold_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_ff  <= 1'b0;
      w_data_ff  <= 8'h00;
      w_lane0_ff <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_ff  <= 1'b1;
      w_data_ff  <= s_axi_wdata[7:0];
      w_lane0_ff <= s_axi_wstrb[0];
    end else if (wr_go) begin
      w_hold_ff  <= 1'b0;
    end
  end

  // write response; unmapped offsets answer SLVERR and store nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= PWO_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_ok ? PWO_RESP_OKAY : PWO_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // ---------------------------------------------------------------------------
  // AXI4-Lite read side: one cycle from address to data
  assign s_axi_arready = !rvalid_ff;
  wire logic rd_go     = s_axi_arvalid && !rvalid_ff;

  // duty reads show the buffer, so a fresh write reads back before it is active
  wire logic [31:0] rd_mux =
    (ar_ofs == `PWO_OFS_CTRL)   ? {24'h00_0000, ctrl_ff & `PWO_CTRL_MASK} :
    (ar_ofs == `PWO_OFS_MODE)   ? {30'h0000_0000, mode_ff} :
    (ar_ofs == `PWO_OFS_DUTY)   ? {24'h00_0000, duty_buf_ff} :  // [R8]
    (ar_ofs == `PWO_OFS_STATUS) ? {31'h0000_0000, sts_ff} :
    (ar_ofs == `PWO_OFS_ENABLE) ? {31'h0000_0000, en_ff} :
    (ar_ofs == `PWO_OFS_COUNT)  ? {22'h00_0000, pin_ff, flop_ff, cnt_ff} :
    32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= PWO_RESP_OKAY;
    end else if (rd_go) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_mux;
      rresp_ff  <= is_mapped(ar_ofs) ? PWO_RESP_OKAY : PWO_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

  // ---------------------------------------------------------------------------
  // source clock enable from the prescaler
  pwo_clk_sel #(
    .FC_DIV    (FC_DIV),
    .FS_DIV    (FS_DIV)
  ) u_clk_sel (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .src_sel   (pwo_src_type'(ctrl_ff[`PWO_CTRL_SRC_HI:`PWO_CTRL_SRC_LO])), // [R14]
    .dv_sel    (mode_ff[`PWO_MODE_DVSEL]),
    .slow_mode (mode_ff[`PWO_MODE_SLOW]),
    .stop_mode (stop_mode),
    .tick      (tick)
  );

  // ---------------------------------------------------------------------------
  // counter, compare and output flop
  wire logic       run      = ctrl_ff[`PWO_CTRL_RUN];
  wire logic       step     = run && tick;                            // [R1]
  wire logic       wrap     = step && (cnt_ff == `PWO_CNT_MAX);       // [R3] [R15]
  wire logic [7:0] cnt_inc  = 8'(cnt_ff + 8'h01);
  // a stopped timer sits at zero; a running one wraps after 256 ticks
  wire logic [7:0] nxt_cnt  = !run ? `PWO_CNT_ZERO :
                              wrap ? `PWO_CNT_ZERO :                  // [R3]
                              step ? cnt_inc : cnt_ff;                // [R2]

  // buffer takes every write; the active copy follows at once when stopped,
  // otherwise only at cycle end. a write in the wrap cycle keeps the old buffer
  // value for this period, which avoids a half-loaded duty
  wire logic [7:0] nxt_buf  = wr_duty ? w_data_ff : duty_buf_ff;
  wire logic [7:0] nxt_act  = (wr_duty && !run) ? w_data_ff :         // [R7]
                              wrap ? duty_buf_ff : duty_act_ff;       // [R6]

  // compare against the value the counter moves to, with the duty it will use
  wire logic       match    = step && (nxt_cnt == nxt_act);           // [R2]

  // flop level is loaded only while the timer is stopped before this write,
  // so the stop write itself leaves the pin where it was
  wire logic       flop_ld  = wr_ctrl && !run;                        // [R11] [R12]
  wire logic       nxt_flop = flop_ld ? w_data_ff[`PWO_CTRL_TFF] :    // [R4]
                              flop_ff ^ wrap ^ match;                 // [R2] [R3]

  // sticky cycle-end flag: a set in the clear cycle wins
  wire logic       nxt_sts  = (sts_ff && !(wr_clear && w_data_ff[`PWO_IRQ_CYCLE_END]))
                              || wrap;                                // [R3]
  wire logic       nxt_en   = wr_enable ? w_data_ff[`PWO_IRQ_CYCLE_END] : en_ff;

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= `PWO_CTRL_RESET;
      mode_ff <= `PWO_MODE_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= w_data_ff & `PWO_CTRL_MASK;
      end
      if (wr_mode) begin
        mode_ff <= w_data_ff[1:0];
      end
    end
  end

  // counting datapath
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff      <= `PWO_CNT_ZERO;
      duty_buf_ff <= `PWO_DUTY_RESET;
      duty_act_ff <= `PWO_DUTY_RESET;
      flop_ff     <= 1'b0;                                            // [R4]
      pin_ff      <= 1'b1;                                            // [R5]
    end else begin
      cnt_ff      <= nxt_cnt;
      duty_buf_ff <= nxt_buf;
      duty_act_ff <= nxt_act;
      flop_ff     <= nxt_flop;
      pin_ff      <= !nxt_flop;                                       // [R5]
    end
  end

  // interrupt status, enable and level output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts_ff <= 1'b0;
      en_ff  <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      sts_ff <= nxt_sts;
      en_ff  <= nxt_en;
      irq_ff <= nxt_sts && nxt_en;
    end
  end

  assign modulated_out_pin   = pin_ff;
  assign cycle_end_interrupt = irq_ff;

endmodule : pwo_pwm8

`default_nettype wire

// >>> pwo_pwm8_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pwo_pwm8_asserts (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic       stop_mode,
  input wire logic       modulated_out_pin,
  input wire logic       cycle_end_interrupt
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // handshake steps used by the bus properties
  sequence s_ar_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_w_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  // reset must be watched while it is active, so no disable here
  property p_rst; disable iff (1'b0) !aresetn |=> modulated_out_pin && !cycle_end_interrupt; endproperty
  property p_rd; s_ar_take |=> s_axi_rvalid; endproperty
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  property p_wr; s_w_take |-> ##[1:2] s_axi_bvalid; endproperty
  property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_awblk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_resp; s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2; endproperty
  // a bus write may reload the flop, so that cycle is left out
  property p_frz; stop_mode[*3] ##1 (stop_mode && !s_axi_bvalid) |-> $stable(modulated_out_pin); endproperty
  a_rst: assert property (p_rst) else $error("reset levels wrong");
  a_rd: assert property (p_rd) else $error("read answer late");
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  a_wr: assert property (p_wr) else $error("write answer late");
  a_arblk: assert property (p_arblk) else $error("read accepted while busy");
  a_awblk: assert property (p_awblk) else $error("write accepted while busy");
  a_resp: assert property (p_resp) else $error("bad write response");
  a_frz: assert property (p_frz) else $error("pin moved in stop mode");
endmodule : pwo_pwm8_asserts
bind pwo_pwm8 pwo_pwm8_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .stop_mode(stop_mode), .modulated_out_pin(modulated_out_pin),
  .cycle_end_interrupt(cycle_end_interrupt));
`default_nettype wire

// >>> pwo_pin_load.sv
`timescale 1ns/1ps
`default_nettype none
module pwo_pin_load (
  input wire logic   aclk,
  input wire logic   pin,
  input wire logic   port_latch,
  output logic [15:0] low_width,
  output logic [15:0] period,
  output logic [7:0]  rises
);
  logic        pad;
  logic        pad_ff = 1'b1;
  logic [15:0] lo_ff = '0;
  logic [15:0] per_ff = '0;
  logic [7:0]  rise_ff = '0;
  // the pad follows the timer only while the port latch is one
  assign pad = pin & port_latch;
  assign rises = rise_ff;
  // measure low time and rise-to-rise period of the pad
  always @(posedge aclk) begin
    pad_ff <= pad;
    per_ff <= (pad && !pad_ff) ? 16'h0001 : per_ff + 16'h0001;
    if (!pad) lo_ff <= pad_ff ? 16'h0001 : lo_ff + 16'h0001;
    if (pad && !pad_ff) begin
      low_width <= lo_ff;
      period    <= per_ff;
      rise_ff   <= rise_ff + 8'h01;
    end
  end
endmodule : pwo_pin_load
`default_nettype wire

// >>> pwo_pwm8_bench.sv
`include "pwo_regs.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin num_errors++; $display("Error %s exp %0h got %0h", nm, ex, gt); end end
module pwo_pwm8_bench;
  import pwo_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic stop_mode = 0, port_latch = 1;
  logic [7:0]  awaddr = '0, araddr = '0, rises;
  logic [31:0] wdata = '0, rdata, v, w;
  logic [1:0]  bresp, rresp, last_resp;
  logic        awready, wready, bvalid, arready, rvalid, pin, irq, exp_tick;
  logic [15:0] low_width, period;
  int          num_errors = 0, total_checks = 0, d1, d2, n;
  pwo_pwm8 #(.FC_DIV(1), .FS_DIV(3)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .stop_mode(stop_mode),
    .modulated_out_pin(pin), .cycle_end_interrupt(irq));
  pwo_pin_load u_load (.aclk(aclk), .pin(pin), .port_latch(port_latch), .low_width(low_width),
    .period(period), .rises(rises));
  always #5 aclk = ~aclk;
  task automatic finish_test();
    if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  // ready levels are read at the edge, before the design's updates land
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && k < 100);
    last_resp = bresp;
    bready <= 1'b0;
    if (k >= 100) `CHK("bvalid", 1'b1, bvalid)
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int k;
    k = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && k < 100);
    d = rdata;
    last_resp = rresp;
    rready <= 1'b0;
    if (k >= 100) `CHK("rvalid", 1'b1, rvalid)
  endtask : rd
  // bounded wait for k rising edges seen at the pad
  task automatic wait_rises(input int k);
    logic [7:0] s0;
    int c;
    s0 = rises;
    c = 0;
    while (int'(8'(rises - s0)) < k && c < 3000) begin
      @(posedge aclk);
      c++;
    end
    if (c >= 3000) `CHK("pin rises", k, int'(8'(rises - s0)))
  endtask : wait_rises
  function automatic logic [15:0] lo_exp(input int d);
    return 16'(256 - d);
  endfunction : lo_exp
  initial begin
    repeat (100000) @(posedge aclk);
    num_errors++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h9978));
    d1 = 16 + ($urandom % 225);
    d2 = 16 + ($urandom % 225);
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("pin", 1'b1, pin)
    rd(`PWO_OFS_CTRL, v);
    `CHK("ctrl", 32'h0000_0000, v)
    rd(8'h1C, v);
    `CHK("rresp", 2'h2, last_resp)
    wr(8'h1C, 32'h0000_00FF);
    `CHK("bresp", 2'h2, last_resp)
    // duty set while stopped is used from the first period
    wr(`PWO_OFS_DUTY, d1);
    wr(`PWO_OFS_CTRL, 32'h0000_0068);
    wait_rises(2);
    `CHK("low", lo_exp(d1), low_width)
    `CHK("period", 16'h0100, period)
    // running update waits for the cycle end
    wait_rises(1);
    wr(`PWO_OFS_DUTY, d2);
    rd(`PWO_OFS_DUTY, v);
    `CHK("duty read", 32'(d2), v)
    wait_rises(1);
    `CHK("low old", lo_exp(d1), low_width)
    wait_rises(1);
    `CHK("low new", lo_exp(d2), low_width)
    // interrupt raise, clear and mask
    wr(`PWO_OFS_ENABLE, 32'h1);
    rd(`PWO_OFS_STATUS, v);
    `CHK("status", 1'b1, v[0])
    `CHK("irq", 1'b1, irq)
    wait_rises(1);
    wr(`PWO_OFS_CLEAR, 32'h1);
    rd(`PWO_OFS_STATUS, v);
    `CHK("status clr", 1'b0, v[0])
    `CHK("irq clr", 1'b0, irq)
    wr(`PWO_OFS_ENABLE, 32'h0);
    wait_rises(1);
    rd(`PWO_OFS_STATUS, v);
    `CHK("status mask", 1'b1, v[0])
    `CHK("irq mask", 1'b0, irq)
    // stop while the pin is low, then park it high
    n = 0;
    while (pin !== 1'b0 && n < 600) begin
      @(posedge aclk);
      n++;
    end
    wr(`PWO_OFS_CTRL, 32'h0000_0060);
    repeat (300) @(posedge aclk);
    `CHK("pin held", 1'b0, pin)
    rd(`PWO_OFS_COUNT, v);
    `CHK("count held", 8'h00, v[7:0])
    wr(`PWO_OFS_CTRL, 32'h0000_0060);
    `CHK("pin park", 1'b1, pin)
    wr(`PWO_OFS_CTRL, 32'h0000_00E0);
    `CHK("pin inv", 1'b0, pin)
    wr(`PWO_OFS_CTRL, 32'h0000_00E8);
    wait_rises(2);
    `CHK("low inv", 16'(d2), low_width)
    // stop mode freezes the counter
    stop_mode <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(`PWO_OFS_COUNT, v);
    repeat (40) @(posedge aclk);
    rd(`PWO_OFS_COUNT, w);
    `CHK("frozen", v[7:0], w[7:0])
    stop_mode <= 1'b0;
    // a running timer would carry its count into the first source probe
    wr(`PWO_OFS_CTRL, 32'h0000_0000);
    // every source under normal, divider-select and slow modes
    for (int m = 0; m < 3; m++) begin
      wr(`PWO_OFS_MODE, m);
      for (int s = 0; s < 8; s++) begin
        // the slowest fc tap fires once per 2048 cycles, so it gets a longer window
        exp_tick = (m == 2) ? (s == 0 || s == 4) : (s <= 6);
        wr(`PWO_OFS_CTRL, (s << 4) | 8);
        repeat ((s == 0 && m == 0) ? 2100 : 300) @(posedge aclk);
        rd(`PWO_OFS_COUNT, v);
        wr(`PWO_OFS_CTRL, 32'h0000_0000);
        `CHK("source tick", exp_tick, v[7:0] !== 8'h00)
      end
    end
    finish_test();
  end
endmodule : pwo_pwm8_bench
`undef CHK
`default_nettype wire
